// ===== hw/kbc_cmd_pkg.sv
// Constants and carrier types for the keyboard/mouse command decoder.
// Assumes one 20 MHz system clock and open-drain device lines.
// Notes on behaviour
// - Command 0xA8 clears config bit 5, re-enabling the pointing-device interface.
// - Command 0xA9 checks pointing-device clock and data lines, loads result byte.
// - Check result codes: 00 ok, 01/02 clock low/high, 03/04 data low/high.
// - Command 0xAB checks keyboard lines, same result coding.
// - Command 0xAA runs self-test; a pass loads 0x55 into output register.
// - Self-test completion sets status bit 0.
// - Failure phase reported in status bits 7-4; 0x8 means passed.
// - Command 0xAD disables keyboard, sets config bit 4.
// - Command 0xAE enables keyboard, clears config bit 4.
// - Command 0xC0 samples the eight-bit input port into the output register.
// - Command 0xC2 copies input port bits 7-4 into status bits 7-4 only.
// - Disabled pointing-device interface has its clock line held low.
// - Output load sets status bit 0; host read of the byte clears it.
package kbc_cmd_pkg;
  localparam logic [7:0] CMD_AUX_ENABLE = 8'ha8;
  localparam logic [7:0] CMD_AUX_CHECK = 8'ha9;
  localparam logic [7:0] CMD_SELF_TEST = 8'haa;
  localparam logic [7:0] CMD_KBD_CHECK = 8'hab;
  localparam logic [7:0] CMD_KBD_DISABLE = 8'had;
  localparam logic [7:0] CMD_KBD_ENABLE = 8'hae;
  localparam logic [7:0] CMD_READ_INPUT = 8'hc0;
  localparam logic [7:0] CMD_POLL_HIGH = 8'hc2;
  // Configuration byte fields and reset value
  localparam int CFG_KBD_OFF_BIT = 4;
  localparam int CFG_AUX_OFF_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Status register fields
  localparam int STATUS_FULL_BIT = 0;
  localparam int STATUS_CODE_LSB = 4;
  localparam logic [3:0] STATUS_CODE_RESET = 4'h0;
  localparam logic [7:0] OUT_RESET = 8'h00;
  // Line check result codes
  localparam logic [7:0] CHECK_OK = 8'h00;
  localparam logic [7:0] CHECK_CLK_LOW = 8'h01;
  localparam logic [7:0] CHECK_CLK_HIGH = 8'h02;
  localparam logic [7:0] CHECK_DATA_LOW = 8'h03;
  localparam logic [7:0] CHECK_DATA_HIGH = 8'h04;
  // Self-test values and phase codes
  localparam logic [7:0] SELF_PASS_BYTE = 8'h55;
  localparam logic [3:0] ST_PH_FIRST = 4'h1;
  localparam logic [3:0] ST_PH_LAST = 4'h6;
  localparam logic [3:0] ST_CODE_PASS = 4'h8;
  // Timing
  localparam int CLK_MHZ = 20;
  localparam int LINE_SETTLE_NS = 5000;
  localparam int SELF_PHASE_NS = 10000;
  localparam int LINE_SETTLE_CYCLES = (LINE_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SELF_PHASE_CYCLES = (SELF_PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMER_W = 8;
  // One open-drain device port: clock and data
  typedef struct packed {
    logic clk;
    logic data;
  } line_pair_t;
endpackage

// ===== hw/line_checker.sv
// Stuck-line checker for one clock/data pair of a device port.
// Assumes synchronised line levels and that drive_out pulls a line low.
`timescale 1ns/10ps
module line_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire kbc_cmd_pkg::line_pair_t lines_in,
  output kbc_cmd_pkg::line_pair_t drive_out,
  output logic done_out,
  output logic [7:0] result_out
);
  typedef enum logic [2:0] {C_IDLE, C_REL_CLK, C_LOW_CLK, C_REL_DATA, C_LOW_DATA} chk_state_t;
  typedef struct packed {
    chk_state_t state;
    logic [kbc_cmd_pkg::TIMER_W-1:0] timer;
    kbc_cmd_pkg::line_pair_t drive;
    logic done;
    logic [7:0] result;
  } chk_t;
  chk_t r_reg, r_next;
  logic settled;

  // Each phase waits long enough for the pull-up and two-flop delay
  assign settled = r_reg.timer == kbc_cmd_pkg::TIMER_W'(kbc_cmd_pkg::LINE_SETTLE_CYCLES - 1);

  // Walk the four phases; the first failing phase ends the check
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.timer = settled ? '0 : r_reg.timer + 1'b1;
    case (r_reg.state)
      C_IDLE: begin
        r_next.timer = '0;
        if (start_in) begin
          r_next.state = C_REL_CLK;
        end
      end
      C_REL_CLK: begin
        if (settled) begin
          if (!lines_in.clk) begin
            r_next.result = kbc_cmd_pkg::CHECK_CLK_LOW;
            r_next.done = 1'b1;
            r_next.state = C_IDLE;
          end else begin
            r_next.drive.clk = 1'b1;
            r_next.state = C_LOW_CLK;
          end
        end
      end
      C_LOW_CLK: begin
        if (settled) begin
          r_next.drive.clk = 1'b0;
          if (lines_in.clk) begin
            r_next.result = kbc_cmd_pkg::CHECK_CLK_HIGH;
            r_next.done = 1'b1;
            r_next.state = C_IDLE;
          end else begin
            r_next.state = C_REL_DATA;
          end
        end
      end
      C_REL_DATA: begin
        if (settled) begin
          if (!lines_in.data) begin
            r_next.result = kbc_cmd_pkg::CHECK_DATA_LOW;
            r_next.done = 1'b1;
            r_next.state = C_IDLE;
          end else begin
            r_next.drive.data = 1'b1;
            r_next.state = C_LOW_DATA;
          end
        end
      end
      C_LOW_DATA: begin
        if (settled) begin
          r_next.drive.data = 1'b0;
          r_next.result = lines_in.data ? kbc_cmd_pkg::CHECK_DATA_HIGH : kbc_cmd_pkg::CHECK_OK;
          r_next.done = 1'b1;
          r_next.state = C_IDLE;
        end
      end
      default: begin
        r_next.state = C_IDLE;
        r_next.drive = '0;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_reg <= '{state: C_IDLE, timer: '0, drive: '0, done: 1'b0, result: kbc_cmd_pkg::CHECK_OK};
    end else begin
      r_reg <= r_next;
    end
  end

  assign drive_out = r_reg.drive;
  assign done_out = r_reg.done;
  assign result_out = r_reg.result;
endmodule

// ===== hw/kbc_cmd_decoder.sv
// Command decoder for a keyboard/mouse controller: line checks,
// self-test, interface enables and input port reads.
// Assumes command writes and output reads are one-cycle pulses from
// host logic on the same clock; device lines and input port are pins.
`timescale 1ns/10ps
module kbc_cmd_decoder (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic [7:0] CMD_BYTE_IN,
  input wire logic OUT_READ_IN,
  input wire logic [7:0] INPUT_PORT_IN,
  input wire logic [3:0] SELF_FAULT_PHASE_IN,
  input wire logic AUX_CLK_IN,
  input wire logic AUX_DATA_IN,
  input wire logic KBD_CLK_IN,
  input wire logic KBD_DATA_IN,
  output logic AUX_CLK_OUT,
  output logic AUX_CLK_OE_OUT,
  output logic AUX_DATA_OUT,
  output logic AUX_DATA_OE_OUT,
  output logic KBD_CLK_OUT,
  output logic KBD_CLK_OE_OUT,
  output logic KBD_DATA_OUT,
  output logic KBD_DATA_OE_OUT,
  output logic [7:0] OUT_DATA_OUT,
  output logic [7:0] STATUS_OUT,
  output logic [7:0] CONFIG_OUT,
  output logic KBD_ENABLE_OUT,
  output logic BUSY_OUT
);
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_SELF} dec_state_t;
  typedef struct packed {
    dec_state_t state;
    logic check_aux;
    logic [3:0] phase;
    logic [kbc_cmd_pkg::TIMER_W-1:0] timer;
    logic [7:0] cfg;
    logic [7:0] out_data;
    logic output_full_flag;
    logic [3:0] status_code;
    logic aux_start;
    logic kbd_start;
    kbc_cmd_pkg::line_pair_t aux_s1;
    kbc_cmd_pkg::line_pair_t aux_s2;
    kbc_cmd_pkg::line_pair_t kbd_s1;
    kbc_cmd_pkg::line_pair_t kbd_s2;
    logic [7:0] port_s1;
    logic [7:0] port_s2;
    kbc_cmd_pkg::line_pair_t aux_oe;
    kbc_cmd_pkg::line_pair_t kbd_oe;
    logic busy;
    logic kbd_en;
  } dec_t;

  dec_t r_reg, r_next;
  kbc_cmd_pkg::line_pair_t aux_drive, kbd_drive;
  logic aux_done, kbd_done;
  logic [7:0] aux_result, kbd_result;
  logic load;
  logic [7:0] load_data;
  logic phase_end;

  // Pointing-device port checker
  line_checker aux_check (
    .clk_in(CLK_SYS_IN),
    .rst_in(RESET_IN),
    .start_in(r_reg.aux_start),
    .lines_in(r_reg.aux_s2),
    .drive_out(aux_drive),
    .done_out(aux_done),
    .result_out(aux_result)
  );

  // Keyboard port checker
  line_checker kbd_check (
    .clk_in(CLK_SYS_IN),
    .rst_in(RESET_IN),
    .start_in(r_reg.kbd_start),
    .lines_in(r_reg.kbd_s2),
    .drive_out(kbd_drive),
    .done_out(kbd_done),
    .result_out(kbd_result)
  );

  assign phase_end = r_reg.timer == kbc_cmd_pkg::TIMER_W'(kbc_cmd_pkg::SELF_PHASE_CYCLES - 1);

  // Decode commands and sequence the long-running ones
  always_comb begin
    r_next = r_reg;
    load = 1'b0;
    load_data = r_reg.out_data;
    r_next.aux_start = 1'b0;
    r_next.kbd_start = 1'b0;
    // Two-flop synchronisers for every pin input
    r_next.aux_s1 = '{clk: AUX_CLK_IN, data: AUX_DATA_IN};
    r_next.aux_s2 = r_reg.aux_s1;
    r_next.kbd_s1 = '{clk: KBD_CLK_IN, data: KBD_DATA_IN};
    r_next.kbd_s2 = r_reg.kbd_s1;
    r_next.port_s1 = INPUT_PORT_IN;
    r_next.port_s2 = r_reg.port_s1;
    case (r_reg.state)
      S_IDLE: begin
        // Commands outside this decoder, and any arriving while busy, are ignored
        if (CMD_WRITE_IN) begin
          case (CMD_BYTE_IN)
            kbc_cmd_pkg::CMD_AUX_ENABLE: begin
              r_next.cfg[kbc_cmd_pkg::CFG_AUX_OFF_BIT] = 1'b0;
            end
            kbc_cmd_pkg::CMD_AUX_CHECK: begin
              r_next.aux_start = 1'b1;
              r_next.check_aux = 1'b1;
              r_next.state = S_CHECK;
            end
            kbc_cmd_pkg::CMD_KBD_CHECK: begin
              r_next.kbd_start = 1'b1;
              r_next.check_aux = 1'b0;
              r_next.state = S_CHECK;
            end
            kbc_cmd_pkg::CMD_SELF_TEST: begin
              r_next.phase = kbc_cmd_pkg::ST_PH_FIRST;
              r_next.timer = '0;
              r_next.state = S_SELF;
            end
            kbc_cmd_pkg::CMD_KBD_DISABLE: begin
              r_next.cfg[kbc_cmd_pkg::CFG_KBD_OFF_BIT] = 1'b1;
            end
            kbc_cmd_pkg::CMD_KBD_ENABLE: begin
              r_next.cfg[kbc_cmd_pkg::CFG_KBD_OFF_BIT] = 1'b0;
            end
            kbc_cmd_pkg::CMD_READ_INPUT: begin
              load = 1'b1;
              load_data = r_reg.port_s2;
            end
            kbc_cmd_pkg::CMD_POLL_HIGH: begin
              r_next.status_code = r_reg.port_s2[7:4];
            end
            default: begin
              load = 1'b0;
            end
          endcase
        end
      end
      S_CHECK: begin
        // Result byte comes from whichever checker was started
        if (r_reg.check_aux && aux_done) begin
          load = 1'b1;
          load_data = aux_result;
          r_next.state = S_IDLE;
        end else if (!r_reg.check_aux && kbd_done) begin
          load = 1'b1;
          load_data = kbd_result;
          r_next.state = S_IDLE;
        end
      end
      S_SELF: begin
        // Each phase runs a fixed time; the fault input picks a phase to fail
        r_next.timer = phase_end ? '0 : r_reg.timer + 1'b1;
        if (phase_end) begin
          if (r_reg.phase == SELF_FAULT_PHASE_IN) begin
            r_next.status_code = r_reg.phase;
            // Reload the kept byte so a same-cycle host read cannot clear completion
            load = 1'b1;
            r_next.state = S_IDLE;
          end else if (r_reg.phase == kbc_cmd_pkg::ST_PH_LAST) begin
            r_next.status_code = kbc_cmd_pkg::ST_CODE_PASS;
            load = 1'b1;
            load_data = kbc_cmd_pkg::SELF_PASS_BYTE;
            r_next.state = S_IDLE;
          end else begin
            r_next.phase = r_reg.phase + 4'h1;
          end
        end
      end
      default: begin
        r_next.state = S_IDLE;
      end
    endcase
    // Host read clears the flag; a load in the same cycle wins
    if (OUT_READ_IN) begin
      r_next.output_full_flag = 1'b0;
    end
    if (load) begin
      r_next.out_data = load_data;
      r_next.output_full_flag = 1'b1;
    end
    // Clock held low while the pointing interface is disabled
    r_next.aux_oe.clk = r_reg.cfg[kbc_cmd_pkg::CFG_AUX_OFF_BIT] | aux_drive.clk;
    r_next.aux_oe.data = aux_drive.data;
    r_next.kbd_oe = kbd_drive;
    // Registered copies so these outputs come straight from flops
    r_next.busy = r_next.state != S_IDLE;
    r_next.kbd_en = ~r_next.cfg[kbc_cmd_pkg::CFG_KBD_OFF_BIT];
  end

  // State register; pin outputs registered so they cannot glitch
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      r_reg <= '{
        state: S_IDLE,
        check_aux: 1'b0,
        phase: kbc_cmd_pkg::ST_PH_FIRST,
        timer: '0,
        cfg: kbc_cmd_pkg::CFG_RESET,
        out_data: kbc_cmd_pkg::OUT_RESET,
        output_full_flag: 1'b0,
        status_code: kbc_cmd_pkg::STATUS_CODE_RESET,
        aux_start: 1'b0,
        kbd_start: 1'b0,
        aux_s1: '1,
        aux_s2: '1,
        kbd_s1: '1,
        kbd_s2: '1,
        port_s1: '0,
        port_s2: '0,
        aux_oe: '0,
        kbd_oe: '0,
        busy: 1'b0,
        kbd_en: ~kbc_cmd_pkg::CFG_RESET[kbc_cmd_pkg::CFG_KBD_OFF_BIT]
      };
    end else begin
      r_reg <= r_next;
    end
  end

  // Open-drain pins only ever pull low, so the data value is constant
  assign AUX_CLK_OUT = 1'b0;
  assign AUX_DATA_OUT = 1'b0;
  assign KBD_CLK_OUT = 1'b0;
  assign KBD_DATA_OUT = 1'b0;
  assign AUX_CLK_OE_OUT = r_reg.aux_oe.clk;
  assign AUX_DATA_OE_OUT = r_reg.aux_oe.data;
  assign KBD_CLK_OE_OUT = r_reg.kbd_oe.clk;
  assign KBD_DATA_OE_OUT = r_reg.kbd_oe.data;
  assign OUT_DATA_OUT = r_reg.out_data;
  assign CONFIG_OUT = r_reg.cfg;
  assign KBD_ENABLE_OUT = r_reg.kbd_en;
  assign BUSY_OUT = r_reg.busy;

  // Bits 3-1 belong to logic outside this decoder and read as zero here
  always_comb begin
    STATUS_OUT = 8'h00;
    STATUS_OUT[7:kbc_cmd_pkg::STATUS_CODE_LSB] = r_reg.status_code;
    STATUS_OUT[kbc_cmd_pkg::STATUS_FULL_BIT] = r_reg.output_full_flag;
  end
endmodule

// ===== test/kbc_cmd_decoder_properties.sv
// Concurrent checks on the command decoder's host-side ports.
// Bound to the decoder from the bench; one clock domain only.
`timescale 1ns/10ps
module kbc_cmd_decoder_properties (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic [7:0] CMD_BYTE_IN,
  input wire logic OUT_READ_IN,
  input wire logic [7:0] INPUT_PORT_IN,
  input wire logic [3:0] SELF_FAULT_PHASE_IN,
  input wire logic [7:0] OUT_DATA_OUT,
  input wire logic [7:0] STATUS_OUT,
  input wire logic [7:0] CONFIG_OUT,
  input wire logic KBD_ENABLE_OUT,
  input wire logic BUSY_OUT
);
  // A command counts only when the decoder is idle
  logic take;
  assign take = CMD_WRITE_IN && !BUSY_OUT;
  // Self-test runs past the longest delay range, so its length is counted here
  logic [10:0] busy_len;
  logic [7:0] last_cmd;
  logic [3:0] last_phase;
  always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      busy_len <= 11'h000;
      last_cmd <= 8'h00;
      last_phase <= 4'h0;
    end else begin
      busy_len <= BUSY_OUT ? busy_len + 11'h001 : 11'h000;
      if (take) begin
        last_cmd <= CMD_BYTE_IN;
        last_phase <= SELF_FAULT_PHASE_IN;
      end
    end
  end
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  AST_AUX_ENABLE: assert property (take && CMD_BYTE_IN == 8'ha8 |=> !CONFIG_OUT[5])
    else $error("aux enable left config bit set");
  AST_KBD_DISABLE: assert property (take && CMD_BYTE_IN == 8'had |=> CONFIG_OUT[4] && !KBD_ENABLE_OUT)
    else $error("keyboard disable not applied");
  AST_KBD_ENABLE: assert property (take && CMD_BYTE_IN == 8'hae |=> !CONFIG_OUT[4] && KBD_ENABLE_OUT)
    else $error("keyboard enable not applied");
  // Port goes through two synchroniser flops before the load
  AST_READ_INPUT: assert property (take && CMD_BYTE_IN == 8'hc0 |=> STATUS_OUT[0] && OUT_DATA_OUT == $past(INPUT_PORT_IN, 3))
    else $error("input port read wrong");
  AST_POLL_HIGH: assert property (take && CMD_BYTE_IN == 8'hc2 |=> $stable(OUT_DATA_OUT) && {STATUS_OUT[7:4], 4'h0} == ($past(INPUT_PORT_IN, 3) & 8'hf0))
    else $error("poll high wrong");
  AST_LINE_CHECK: assert property (take && (CMD_BYTE_IN == 8'ha9 || CMD_BYTE_IN == 8'hab) |=> BUSY_OUT ##[90:420] (!BUSY_OUT && STATUS_OUT[0] && OUT_DATA_OUT <= 8'h04))
    else $error("line check result missing");
  // Six phases of 200 cycles each; a fault at phase k ends after k phases
  AST_SELF_PASS: assert property ($fell(BUSY_OUT) && last_cmd == 8'haa && !(last_phase inside {[4'h1:4'h6]}) |-> busy_len == 11'h4b0 && STATUS_OUT == 8'h81 && OUT_DATA_OUT == 8'h55)
    else $error("self-test pass not reported");
  AST_SELF_FAIL: assert property ($fell(BUSY_OUT) && last_cmd == 8'haa && last_phase inside {[4'h1:4'h6]} |-> busy_len == 11'(last_phase) * 11'h0c8 && STATUS_OUT[7:4] == last_phase && STATUS_OUT[0])
    else $error("self-test fault code wrong");
  // No command may keep the decoder busy for 1250 cycles, 50 more than a full self-test
  AST_BUSY_BOUND: assert property (BUSY_OUT |-> busy_len < 11'h4e2)
    else $error("decoder busy too long");
  AST_READ_CLEAR: assert property (OUT_READ_IN && !CMD_WRITE_IN && !BUSY_OUT |=> !STATUS_OUT[0])
    else $error("output full flag not cleared");
endmodule

// ===== test/kbc_line_model.sv
// Pulled-up clock and data lines of one attached device.
// A fault pins a line whatever the decoder drives; oe high pulls low.
`timescale 1ns/10ps
module kbc_line_model (
  input wire kbc_cmd_pkg::line_pair_t oe_in,
  input wire logic [2:0] fault_in,
  output kbc_cmd_pkg::line_pair_t lines_out
);
  // Fault codes: 1 clock low, 2 clock high, 3 data low, 4 data high
  always_comb begin
    lines_out.clk = fault_in == 3'h1 ? 1'b0 : fault_in == 3'h2 ? 1'b1 : !oe_in.clk;
    lines_out.data = fault_in == 3'h3 ? 1'b0 : fault_in == 3'h4 ? 1'b1 : !oe_in.data;
  end
endmodule

// ===== test/test_kbc_cmd_decoder.sv
// Self-checking bench for the command decoder with line models.
// Inputs change 1 ns after the rising edge; expectations from an integer model.
`timescale 1ns/10ps
module test_kbc_cmd_decoder;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] port = 8'h00;
  logic [3:0] phase = 4'h0;
  logic [2:0] aux_f = 3'h0;
  logic [2:0] kbd_f = 3'h0;
  wire kbc_cmd_pkg::line_pair_t aux_oe, kbd_oe;
  kbc_cmd_pkg::line_pair_t aux_ln, kbd_ln;
  logic [7:0] out_d, stat, cfg;
  logic kbd_en, busy;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int e_cfg, e_out, e_code, e_full;
  logic [31:0] seed = 32'h00011df0;
  kbc_cmd_decoder dut (.CLK_SYS_IN(clk), .RESET_IN(rst), .CMD_WRITE_IN(wr), .CMD_BYTE_IN(cmd),
    .OUT_READ_IN(rd), .INPUT_PORT_IN(port), .SELF_FAULT_PHASE_IN(phase),
    .AUX_CLK_IN(aux_ln.clk), .AUX_DATA_IN(aux_ln.data), .KBD_CLK_IN(kbd_ln.clk), .KBD_DATA_IN(kbd_ln.data),
    .AUX_CLK_OUT(), .AUX_CLK_OE_OUT(aux_oe.clk), .AUX_DATA_OUT(), .AUX_DATA_OE_OUT(aux_oe.data),
    .KBD_CLK_OUT(), .KBD_CLK_OE_OUT(kbd_oe.clk), .KBD_DATA_OUT(), .KBD_DATA_OE_OUT(kbd_oe.data),
    .OUT_DATA_OUT(out_d), .STATUS_OUT(stat), .CONFIG_OUT(cfg), .KBD_ENABLE_OUT(kbd_en), .BUSY_OUT(busy));
  kbc_line_model aux_m (.oe_in(aux_oe), .fault_in(aux_f), .lines_out(aux_ln));
  kbc_line_model kbd_m (.oe_in(kbd_oe), .fault_in(kbd_f), .lines_out(kbd_ln));
  // 20 MHz system clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Hang guard: about three and a half times the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      summarize();
    end
  end
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // Whole visible state against the model
  task automatic compare_all();
    check("config", cfg, e_cfg[7:0]);
    check("output", out_d, e_out[7:0]);
    check("status", stat, {e_code[3:0], 3'h0, e_full[0]});
    check("kbd enable", {7'h0, kbd_en}, {7'h0, ~e_cfg[4]});
    // Idle lines are released, except the pointing clock, which is held while that interface is disabled
    check("line oe", {4'h0, aux_oe.clk, aux_oe.data, kbd_oe.clk, kbd_oe.data}, {4'h0, e_cfg[5], 3'h0});
  endtask
  // One command pulse, then wait out any check or self-test
  task automatic do_cmd(input logic [7:0] c);
    @(posedge clk);
    #1 wr = 1'b1;
    cmd = c;
    @(posedge clk);
    #1 wr = 1'b0;
    while (busy !== 1'b0) begin
      @(posedge clk);
      #1;
    end
    case (c)
      8'ha8: e_cfg &= ~32;
      8'had: e_cfg |= 16;
      8'hae: e_cfg &= ~16;
      8'hc0: begin
        e_out = port;
        e_full = 1;
      end
      8'hc2: e_code = port >> 4;
      8'ha9: begin
        e_out = aux_f;
        e_full = 1;
      end
      8'hab: begin
        e_out = kbd_f;
        e_full = 1;
      end
      8'haa: begin
        e_full = 1;
        e_code = (phase >= 1 && phase <= 6) ? phase : 8;
        if (e_code == 8) e_out = 8'h55;
      end
      default: ;
    endcase
    compare_all();
  endtask
  task automatic do_read();
    @(posedge clk);
    #1 rd = 1'b1;
    @(posedge clk);
    #1 rd = 1'b0;
    e_full = 0;
    compare_all();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    e_cfg = 0;
    e_out = 0;
    e_code = 0;
    e_full = 0;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    compare_all();
    repeat (3) @(posedge clk);
    do_cmd(8'had);
    do_cmd(8'hae);
    do_cmd(8'had);
    do_cmd(8'ha8);
    // Poll before read, so an output load by the poll would show
    repeat (4) begin
      port = xs();
      repeat (4) @(posedge clk);
      do_cmd(8'hc2);
      do_cmd(8'hc0);
      do_read();
    end
    // Every check code on both device ports
    for (int f = 0; f <= 4; f++) begin
      aux_f = f[2:0];
      do_cmd(8'ha9);
      do_read();
      aux_f = 3'h0;
      kbd_f = f[2:0];
      do_cmd(8'hab);
      do_read();
      kbd_f = 3'h0;
    end
    // Pass first, then each failing phase keeps the pass byte
    for (int k = 0; k <= 6; k++) begin
      phase = k[3:0];
      do_cmd(8'haa);
      do_read();
    end
    summarize();
  end
endmodule
bind kbc_cmd_decoder kbc_cmd_decoder_properties chk (.CLK_SYS_IN, .RESET_IN, .CMD_WRITE_IN, .CMD_BYTE_IN,
  .OUT_READ_IN, .INPUT_PORT_IN, .SELF_FAULT_PHASE_IN, .OUT_DATA_OUT, .STATUS_OUT, .CONFIG_OUT,
  .KBD_ENABLE_OUT, .BUSY_OUT);
